// file: core/gpt_pkg.sv
/*
  package of the general-purpose 16-bit timer: register indices, control
  field layout, reset values, prescaler terminal counts and shared types.
  assumes a 32-bit classic wishbone slave; each register index is eight
  bytes apart on the bus.
*/
package gpt_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0]  GPT_IDX_COUNT   = 10'h100;
  localparam logic [9:0]  GPT_IDX_PERIOD  = 10'h102;
  localparam logic [9:0]  GPT_IDX_CONTROL = 10'h104;
  localparam logic [9:0]  GPT_IDX_STATUS  = 10'h106;
  localparam logic [9:0]  GPT_IDX_MASK    = 10'h108;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int          GPT_BIT_ON      = 15;
  localparam int          GPT_BIT_IDLE    = 13;
  localparam int          GPT_BIT_GATE    = 6;
  localparam int          GPT_BIT_PS_HI   = 5;
  localparam int          GPT_BIT_PS_LO   = 4;
  localparam int          GPT_BIT_SYNC    = 2;
  localparam int          GPT_BIT_CS      = 1;
  localparam logic [15:0] GPT_RST_COUNT   = 16'h0000;
  localparam logic [15:0] GPT_RST_PERIOD  = 16'hffff;
  localparam logic [15:0] GPT_RST_CONTROL = 16'h0000;
  localparam logic [1:0]  GPT_RST_IRQ     = 2'h0;

  // status / mask bit positions
  localparam int          GPT_IRQ_MATCH   = 0;
  localparam int          GPT_IRQ_GATE    = 1;

  // prescale select codes and their terminal counts (divide minus one)
  localparam logic [1:0]  GPT_PS_1        = 2'h0;
  localparam logic [1:0]  GPT_PS_8        = 2'h1;
  localparam logic [1:0]  GPT_PS_64       = 2'h2;
  localparam logic [1:0]  GPT_PS_256      = 2'h3;
  localparam logic [7:0]  GPT_TC_1        = 8'h00;
  localparam logic [7:0]  GPT_TC_8        = 8'h07;
  localparam logic [7:0]  GPT_TC_64       = 8'h3f;
  localparam logic [7:0]  GPT_TC_256      = 8'hff;

  typedef struct packed {
    logic       timer_on;
    logic       stop_in_idle;
    logic       gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic       external_sync_select;
    logic       clock_source_select;
  } gpt_ctrl_s;

  typedef enum logic [1:0] {
    GPT_MODE_TIMER,
    GPT_MODE_GATED,
    GPT_MODE_SYNC_CNT,
    GPT_MODE_ASYNC_CNT
  } gpt_mode_e;

endpackage : gpt_pkg

// file: core/gpt_timer16.sv
/*
  16-bit general-purpose timer/counter with gated accumulation, a
  four-setting prescaler, idle/sleep gating and a masked interrupt.
  assumes a classic wishbone master on clk_i, cpu power-state levels from
  logic on clk_i, and an external clock/gate pin from outside the domain.
*/
`timescale 1ns/1ps

module gpt_timer16
  import gpt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_clock_gate_pin_i,
  input  wire logic        cpu_idle_i,
  input  wire logic        cpu_sleep_i,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old_v[15:8], sel[0] ? wd[7:0] : old_v[7:0]};
  endfunction : merge16

  function automatic logic [7:0] ps_limit(input logic [1:0] code);
    case (code)
      GPT_PS_1:   ps_limit = GPT_TC_1;
      GPT_PS_8:   ps_limit = GPT_TC_8;
      GPT_PS_64:  ps_limit = GPT_TC_64;
      GPT_PS_256: ps_limit = GPT_TC_256;
      default:    ps_limit = GPT_TC_1;
    endcase
  endfunction : ps_limit

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] count_q, count_d;
  logic [15:0] period_q;
  gpt_ctrl_s   ctrl_q;
  logic [1:0]  status_q, status_d;
  logic [1:0]  mask_q;
  logic [7:0]  ps_q, ps_d;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        pin_meta_q, pin_sync_q, pin_prev_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // ack comes one cycle after the request; writes and read side effects land
  // on the edge where the master sees ack, so nothing happens twice.
  wire logic [9:0]  reg_idx    = wb_adr_i[11:2];
  wire logic        bus_req    = wb_cyc_i & wb_stb_i;
  wire logic        bus_done   = bus_req & ack_q;
  wire logic        wr_en      = bus_done & wb_we_i;
  wire logic        rd_en      = bus_done & ~wb_we_i;
  wire logic        hit_count  = (reg_idx == GPT_IDX_COUNT);
  wire logic        hit_period = (reg_idx == GPT_IDX_PERIOD);
  wire logic        hit_ctrl   = (reg_idx == GPT_IDX_CONTROL);
  wire logic        hit_status = (reg_idx == GPT_IDX_STATUS);
  wire logic        hit_mask   = (reg_idx == GPT_IDX_MASK);
  wire logic        count_wr   = wr_en & hit_count;
  wire logic        ctrl_wr    = wr_en & hit_ctrl;
  wire logic        status_rd  = rd_en & hit_status;

  wire logic [15:0] ctrl_word  = {ctrl_q.timer_on, 1'b0, ctrl_q.stop_in_idle, 6'h00,
                                  ctrl_q.gate_accumulate_enable, ctrl_q.prescale_select,
                                  1'b0, ctrl_q.external_sync_select,
                                  ctrl_q.clock_source_select, 1'b0};
  wire logic [15:0] ctrl_new   = merge16(ctrl_word, wb_dat_i, wb_sel_i);
  wire logic        on_clear   = ctrl_wr & ctrl_q.timer_on & ~ctrl_new[GPT_BIT_ON];

  wire logic [31:0] rdata_mux  = hit_count  ? {16'h0000, count_q}  :
                                 hit_period ? {16'h0000, period_q} :
                                 hit_ctrl   ? {16'h0000, ctrl_word} :
                                 hit_status ? {30'h00000000, status_q} :
                                 hit_mask   ? {30'h00000000, mask_q} : 32'h00000000;

  // ---------------------------------------------------------------
  // mode and clock selection
  // ---------------------------------------------------------------
  gpt_mode_e mode;
  always_comb begin
    if (!ctrl_q.clock_source_select) begin
      mode = ctrl_q.gate_accumulate_enable ? GPT_MODE_GATED : GPT_MODE_TIMER;
    end else begin
      mode = ctrl_q.external_sync_select ? GPT_MODE_SYNC_CNT : GPT_MODE_ASYNC_CNT;
    end
  end

  // the pin is sampled twice before use in every mode; asynchronous mode
  // differs only in that it survives sleep.
  wire logic pin_rise = pin_sync_q & ~pin_prev_q;
  wire logic pin_fall = ~pin_sync_q & pin_prev_q;

  logic base_tick;
  logic power_ok;
  always_comb begin
    base_tick = 1'b0;
    power_ok  = 1'b0;
    case (mode)
      GPT_MODE_TIMER: begin
        base_tick = 1'b1;
        power_ok  = ~cpu_sleep_i & ~(cpu_idle_i & ctrl_q.stop_in_idle);
      end
      GPT_MODE_GATED: begin
        base_tick = pin_sync_q;
        power_ok  = ~cpu_sleep_i & ~(cpu_idle_i & ctrl_q.stop_in_idle);
      end
      GPT_MODE_SYNC_CNT: begin
        base_tick = pin_rise;
        power_ok  = ~cpu_sleep_i & ~(cpu_idle_i & ctrl_q.stop_in_idle);
      end
      GPT_MODE_ASYNC_CNT: begin
        base_tick = pin_rise;
        power_ok  = ~(cpu_idle_i & ctrl_q.stop_in_idle);
      end
      default: begin
        base_tick = 1'b0;
        power_ok  = 1'b0;
      end
    endcase
  end

  wire logic tick_in    = ctrl_q.timer_on & power_ok & base_tick;
  wire logic ps_wrap    = (ps_q == ps_limit(ctrl_q.prescale_select));
  wire logic count_tick = tick_in & ps_wrap;
  wire logic at_period  = (count_q == period_q);
  wire logic match_evt  = count_tick & at_period & ~count_wr;
  wire logic gate_evt   = ctrl_q.timer_on & (mode == GPT_MODE_GATED) & pin_fall;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    ps_d = ps_q;
    if ((count_wr & ctrl_q.timer_on) | on_clear) begin
      ps_d = 8'h00;
    end else if (tick_in) begin
      ps_d = ps_wrap ? 8'h00 : ps_q + 8'h01;
    end
  end

  always_comb begin
    count_d = count_q;
    if (count_wr) begin
      count_d = merge16(count_q, wb_dat_i, wb_sel_i);
    end else if (count_tick) begin
      count_d = at_period ? GPT_RST_COUNT : count_q + 16'h0001;
    end
  end

  // a new event in the clearing read's cycle survives it
  always_comb begin
    status_d = status_rd ? GPT_RST_IRQ : status_q;
    if (match_evt) begin
      status_d[GPT_IRQ_MATCH] = 1'b1;
    end
    if (gate_evt) begin
      status_d[GPT_IRQ_GATE] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= ext_clock_gate_pin_i;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= bus_req & ~ack_q;
      rdata_q <= rdata_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q  <= GPT_RST_COUNT;
      ps_q     <= 8'h00;
      status_q <= GPT_RST_IRQ;
    end else begin
      count_q  <= count_d;
      ps_q     <= ps_d;
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_q <= GPT_RST_PERIOD;
      ctrl_q   <= gpt_ctrl_s'(7'h00);
      mask_q   <= GPT_RST_IRQ;
    end else begin
      if (wr_en & hit_period) begin
        period_q <= merge16(period_q, wb_dat_i, wb_sel_i);
      end
      if (ctrl_wr) begin
        ctrl_q.timer_on               <= ctrl_new[GPT_BIT_ON];
        ctrl_q.stop_in_idle           <= ctrl_new[GPT_BIT_IDLE];
        ctrl_q.gate_accumulate_enable <= ctrl_new[GPT_BIT_GATE];
        ctrl_q.prescale_select        <= ctrl_new[GPT_BIT_PS_HI:GPT_BIT_PS_LO];
        ctrl_q.external_sync_select   <= ctrl_new[GPT_BIT_SYNC];
        ctrl_q.clock_source_select    <= ctrl_new[GPT_BIT_CS];
      end
      if (wr_en & hit_mask & wb_sel_i[0]) begin
        mask_q <= wb_dat_i[1:0];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign irq_o    = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_wrap;
    count_tick && at_period && !count_wr |=> count_q == GPT_RST_COUNT;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

  property p_inc;
    count_tick && !at_period && !count_wr |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("count did not advance by one");

  property p_idle_hold;
    cpu_idle_i && ctrl_q.stop_in_idle && !count_wr && !ctrl_wr |=> $stable(count_q) && $stable(ps_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved in idle");

  property p_async_idle;
    mode == GPT_MODE_ASYNC_CNT && cpu_idle_i && ctrl_q.stop_in_idle && !count_wr |=> $stable(count_q);
  endproperty
  a_async_idle: assert property (p_async_idle) else $error("async count moved in idle");

  property p_sleep;
    cpu_sleep_i && mode != GPT_MODE_ASYNC_CNT && !count_wr |=> $stable(count_q);
  endproperty
  a_sleep: assert property (p_sleep) else $error("count moved in sleep");

  property p_gate_low;
    mode == GPT_MODE_GATED && !pin_sync_q && !count_wr && !ctrl_wr |=> $stable(count_q) && $stable(ps_q);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated count moved with gate low");

  property p_ext_noedge;
    ctrl_q.clock_source_select && !pin_rise && !count_wr |=> $stable(count_q);
  endproperty
  a_ext_noedge: assert property (p_ext_noedge) else $error("counter moved without edge");

  property p_ps_clear;
    count_wr && ctrl_q.timer_on |=> ps_q == 8'h00;
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

  property p_off_frozen;
    !ctrl_q.timer_on |=> $stable(ps_q) && ($stable(count_q) || $past(count_wr));
  endproperty
  a_off_frozen: assert property (p_off_frozen) else $error("prescaler moved while off");

  property p_ps8;
    ctrl_q.timer_on && ctrl_q.prescale_select == GPT_PS_8 && ps_q == GPT_TC_1 && tick_in && !count_wr
      && !ctrl_wr |=> ps_q == 8'h01;
  endproperty
  a_ps8: assert property (p_ps8) else $error("prescaler did not step");

  property p_ctrl_keeps;
    ctrl_wr && !count_tick |=> $stable(count_q);
  endproperty
  a_ctrl_keeps: assert property (p_ctrl_keeps) else $error("control write changed count");

  property p_match_flag;
    match_evt |=> status_q[GPT_IRQ_MATCH] ##0 (irq_o == mask_q[GPT_IRQ_MATCH] || status_q[GPT_IRQ_GATE]);
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set");

  property p_gate_flag;
    gate_evt |=> status_q[GPT_IRQ_GATE];
  endproperty
  a_gate_flag: assert property (p_gate_flag) else $error("gate flag not set");

  property p_flag_sticky;
    status_q[GPT_IRQ_MATCH] && !status_rd |=> status_q[GPT_IRQ_MATCH];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("match flag cleared by itself");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  c_wrap:  cover property (match_evt);
  c_gate:  cover property (gate_evt);
  c_async: cover property (mode == GPT_MODE_ASYNC_CNT && cpu_sleep_i && count_tick);
  c_ps256: cover property (ctrl_q.prescale_select == GPT_PS_256 && count_tick);

endmodule : gpt_timer16

// file: tb/gpt_pin_src.sv
/*
  model of the external clock/gate source on the timer pin.
  assumes the bench controls it on clk_i: run_i makes a slow clock,
  otherwise the pin follows gate_i.
*/
`timescale 1ns/1ps

module gpt_pin_src (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic gate_i,
  output logic      pin_o
);
  logic [1:0] ph_q;
  logic       tog_q;

  // -------------------------------------------------
  // clock of eight cycles per period, still when idle
  // -------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      ph_q  <= 2'h0;
      tog_q <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) tog_q <= ~tog_q;
    end
  end

  // gate level passes straight through between frames
  assign pin_o = run_i ? tog_q : gate_i;
endmodule : gpt_pin_src

// file: tb/gpt_timer16_tb.sv
/*
  self-checking bench of the 16-bit timer over classic wishbone.
  assumes the idle input can freeze the timer, so counting spans are exact.
*/
`timescale 1ns/1ps

module gpt_timer16_tb;
  import gpt_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, pin, run, gate, idle, sleep;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr, r;
  int          n_fail, samples_checked;
  localparam logic [11:0] A_CNT = {GPT_IDX_COUNT, 2'h0};
  localparam logic [11:0] A_PER = {GPT_IDX_PERIOD, 2'h0};
  localparam logic [11:0] A_CTL = {GPT_IDX_CONTROL, 2'h0};
  localparam logic [11:0] A_STA = {GPT_IDX_STATUS, 2'h0};
  localparam logic [11:0] A_MSK = {GPT_IDX_MASK, 2'h0};

  gpt_timer16 u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .ext_clock_gate_pin_i(pin), .cpu_idle_i(idle),
    .cpu_sleep_i(sleep), .irq_o(irq));
  gpt_pin_src u_src (.clk_i(clk_i), .run_i(run), .gate_i(gate), .pin_o(pin));

  // ---------------------------------------------
  // bus and check tasks
  // ---------------------------------------------
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("[ERR] %0t bus ack timeout", $time);
    end
    r = dr;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    wb(1'b0, a, 32'h0);
    chk(r, exp, m);
  endtask : rd

  // exactly n edges see idle low, then the timer freezes again
  task automatic run_for(input int n);
    @(posedge clk_i);
    idle <= 1'b0;
    repeat (n) @(posedge clk_i);
    idle <= 1'b1;
  endtask : run_for

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  logic [31:0] ps_exp [4] = '{32'h100, 32'h20, 32'h4, 32'h1};
  logic [15:0] c_ctl [4] = '{16'h8006, 16'h8002, 16'h8006, 16'ha002};
  logic        c_slp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic        c_idl [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [31:0] c_exp [4] = '{32'h5, 32'h5, 32'h0, 32'h0};
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h0; sel = 4'h0;
    dw = 32'h0; run = 1'b0; gate = 1'b0; idle = 1'b1; sleep = 1'b0;
    n_fail = 0; samples_checked = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_CNT, 32'h0, "count reset");
    rd(A_PER, 32'hffff, "period reset");
    rd(A_CTL, 32'h0, "control reset");
    rd(A_STA, 32'h0, "status reset");
    rd(A_MSK, 32'h0, "mask reset");
    rd(12'h00c, 32'h0, "unmapped read");
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, A_CTL, 32'ha000 | (p << 4));
      wb(1'b1, A_CNT, 32'h0);
      run_for(256);
      wb(1'b1, A_CTL, 32'h0);
      rd(A_CNT, ps_exp[p], "prescaled count");
    end
    $display("test prescale done");
    wb(1'b1, A_PER, 32'h3);
    wb(1'b1, A_CTL, 32'ha000);
    wb(1'b1, A_CNT, 32'h0);
    run_for(4);
    rd(A_CNT, 32'h0, "wrap at period");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wb(1'b1, A_MSK, 32'h1);
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h1, "match irq");
    run_for(2);
    rd(A_CNT, 32'h2, "keeps counting");
    rd(A_STA, 32'h1, "match flag");
    rd(A_STA, 32'h0, "flag cleared by read");
    chk({31'h0, irq}, 32'h0, "irq dropped");
    $display("test wrap done");
    wb(1'b1, A_PER, 32'hffff);
    wb(1'b1, A_CTL, 32'ha040);
    wb(1'b1, A_CNT, 32'h0);
    @(posedge clk_i);
    idle <= 1'b0;
    gate <= 1'b1;
    repeat (20) @(posedge clk_i);
    gate <= 1'b0;
    repeat (10) @(posedge clk_i);
    idle <= 1'b1;
    rd(A_CNT, 32'h14, "gated count");
    rd(A_STA, 32'h2, "gate fall flag");
    $display("test gate done");
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, A_CTL, {16'h0, c_ctl[c]});
      wb(1'b1, A_CNT, 32'h0);
      @(posedge clk_i);
      idle <= c_idl[c];
      sleep <= c_slp[c];
      run <= 1'b1;
      repeat (40) @(posedge clk_i);
      run <= 1'b0;
      repeat (10) @(posedge clk_i);
      idle <= 1'b1;
      sleep <= 1'b0;
      rd(A_CNT, c_exp[c], "external count");
    end
    $display("test counter done");
    tally_and_finish();
  end
endmodule : gpt_timer16_tb
